// ===== hw/evt_timer_pkg.sv
/*
  Package for the dual timer/event counter block: register indices,
  control field layout, mode codes and reset values.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package evt_timer_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTR_A_VALUE   = 8'h0d;
  localparam logic [7:0] IDX_CTR_A_CONTROL = 8'h0e;
  localparam logic [7:0] IDX_CTR_B_HIGH    = 8'h0f;
  localparam logic [7:0] IDX_CTR_B_LOW     = 8'h10;
  localparam logic [7:0] IDX_CTR_B_CONTROL = 8'h11;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h20;
  localparam logic [7:0] IDX_PORT_CTRL     = 8'h21;

  // Bit positions in the irq status register
  localparam int IRQ_A_EN_BIT  = 0;
  localparam int IRQ_B_EN_BIT  = 1;
  localparam int IRQ_B_FLG_BIT = 4;
  localparam int IRQ_A_FLG_BIT = 6;

  // Bit positions in the port control register
  localparam int PORT_LATCH_BIT = 0;
  localparam int PORT_DIR_BIT   = 1;
  localparam int PORT_PIN_BIT   = 2;

  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Mask for the unused low bits of counter B's control register
  localparam logic [7:0] CTR_B_CTRL_MASK = 8'hf8;
  // Mask for the unused bit 5 of counter A's control register
  localparam logic [7:0] CTR_A_CTRL_MASK = 8'hdf;

  // Operating modes held in control bits 7:6
  typedef enum logic [1:0] {
    MODE_UNUSED = 2'b00,
    MODE_EVENT  = 2'b01,
    MODE_TIMER  = 2'b10,
    MODE_PULSE  = 2'b11
  } mode_t;

  // Control register layout, shared by both counters
  typedef struct packed {
    mode_t      mode;      // Bits 7:6
    logic       clk_sel;   // Bit 5, counter B only
    logic       run;       // Bit 4
    logic       edge_sel;  // Bit 3
    logic [2:0] presc;     // Bits 2:0, counter A only
  } ctr_ctrl_t;

endpackage

// ===== hw/prescale_gen.sv
/*
  Free-running prescaler: selectable divided tick for counter A,
  a quarter-rate tick for counter B, and the shared count for PWM.
  Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module prescale_gen
  import evt_timer_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] sel,
  output logic      [6:0] div_count,
  output logic            tick_a,
  output logic            tick_quarter
);

  // Free-running stage count
  logic [6:0] stage_reg;

  // Low-bit mask for a divide by two to the power of code
  function automatic logic [6:0] stage_mask(input logic [2:0] code);
    stage_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // Counter advances every cycle, never reset mid-run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= 7'h00;
    end else begin
      stage_reg <= stage_reg + 7'h01;
    end
  end

  // Tick when all masked bits are ones; code 0 ticks every cycle
  assign tick_a       = ((stage_reg & stage_mask(sel)) == stage_mask(sel));
  assign tick_quarter = (stage_reg[1:0] == 2'b11);
  // Same count doubles as the PWM period counter
  assign div_count    = stage_reg;

endmodule

// ===== hw/count_core.sv
/*
  One count-up timer/event counter with event, timer and pulse-width
  modes. Preload and run bit live in the caller.
  Assumes event input synchronous to pclk.
*/
`timescale 1ns/10ps
module count_core
  import evt_timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire mode_t            mode,
  input  wire logic             edge_sel,
  input  wire logic             run,
  input  wire logic             int_tick,
  input  wire logic             event_in,
  input  wire logic             block,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic [WIDTH-1:0] preload,
  output logic      [WIDTH-1:0] count,
  output logic                  overflow,
  output logic                  measure_done
);

  logic             event_prev_reg;  // Last event input level
  logic             measuring_reg;   // Pulse being timed
  logic [WIDTH-1:0] count_reg;       // Running count
  logic             ovf_reg;         // Overflow pulse
  logic             rise;
  logic             fall;
  logic             start_edge;
  logic             stop_edge;
  logic             tick;

  assign rise = event_in & ~event_prev_reg;
  assign fall = ~event_in & event_prev_reg;
  // Edge select 1 starts on rising, stops on falling
  assign start_edge = edge_sel ? rise : fall;
  assign stop_edge  = edge_sel ? fall : rise;

  // Edge history for the event input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_prev_reg <= 1'b0;
    end else begin
      event_prev_reg <= event_in;
    end
  end

  // Measurement window: one pulse per run, result then held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      measuring_reg <= 1'b0;
    end else if (!run || mode != MODE_PULSE) begin
      measuring_reg <= 1'b0;
    end else if (!measuring_reg && start_edge) begin
      measuring_reg <= 1'b1;
    end else if (measuring_reg && stop_edge) begin
      measuring_reg <= 1'b0;
    end
  end

  assign measure_done = (mode == MODE_PULSE) & run & measuring_reg
                        & stop_edge;

  // Count source per mode; a read in progress holds the clock off
  always_comb begin
    unique case (mode)
      MODE_EVENT:  tick = edge_sel ? fall : rise;
      MODE_TIMER:  tick = int_tick;
      MODE_PULSE:  tick = measuring_reg & int_tick;
      MODE_UNUSED: tick = 1'b0;
    endcase
    tick = tick & run & ~block;
  end

  // Count up to all ones, then reload from preload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= COUNT_RESET[WIDTH-1:0];
      ovf_reg   <= 1'b0;
    end else begin
      ovf_reg <= 1'b0;
      if (load) begin
        count_reg <= load_val;
      end else if (tick) begin
        if (&count_reg) begin
          count_reg <= preload;
          ovf_reg   <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

  assign count    = count_reg;
  assign overflow = ovf_reg;

  // Read in progress freezes the count
  read_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (block && !load) |=> (count_reg == $past(count_reg)))
    else $error("count moved while read blocked");

  // Unused mode never advances
  unused_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_UNUSED && !load) |=> !ovf_reg &&
      (count_reg == $past(count_reg)))
    else $error("count moved in unused mode");

endmodule

// ===== hw/event_timer.sv
/*
  Dual timer/event counter with frequency divider output, APB slave.
  Counter A is 8-bit with prescaler, counter B 16-bit.
  Assumes event pins, the 32768Hz source and option straps are
  synchronous to pclk; APB master per the AMBA APB protocol.
*/
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module event_timer
  import evt_timer_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ctr_a_event_input,
  input  wire logic        ctr_b_event_input,
  input  wire logic        slow_clk_in,
  input  wire logic        divider_option_en,
  input  wire logic        divider_from_ctr_b,
  input  wire logic        shared_divider_pin_in,
  output logic             shared_divider_pin_out,
  output logic             shared_divider_pin_oe,
  output logic             ctr_a_irq,
  output logic             ctr_b_irq,
  output logic             wake_up,
  output logic [6:0]       pwm_count
);

  // Software-visible state
  ctr_ctrl_t   a_ctrl_reg;      // Counter A control
  ctr_ctrl_t   b_ctrl_reg;      // Counter B control
  logic [7:0]  a_preload_reg;   // Counter A preload
  logic [15:0] b_preload_reg;   // Counter B preload
  logic [7:0]  b_low_buf_reg;   // Counter B low-byte buffer
  logic        a_irq_en_reg;    // Counter A irq enable
  logic        b_irq_en_reg;    // Counter B irq enable
  logic        a_flag_reg;      // Counter A overflow flag
  logic        b_flag_reg;      // Counter B overflow flag
  logic        pin_latch_reg;   // Shared pin data latch
  logic        pin_dir_reg;     // Shared pin direction, 1 = out
  logic        divider_reg;     // Divided overflow level
  logic        wake_reg;        // Wake-up pulse
  logic        slow_prev_reg;   // Last 32768Hz level
  logic [31:0] prdata_reg;      // Read data

  // Bus decode
  logic [7:0]  idx;
  logic        setup_rd;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;

  // Counter wiring
  logic [7:0]  count_a;
  logic [15:0] count_b;
  logic        ovf_a;
  logic        ovf_b;
  logic        done_a;
  logic        done_b;
  logic        tick_a;
  logic        tick_quarter;
  logic        slow_tick;
  logic        tick_b;
  logic        load_a;
  logic        load_b;
  logic        block_a;
  logic        block_b;
  logic        sel_ovf;

  // Address lands on a word of its own; low two bits ignored
  assign idx = {2'b00, paddr[7:2]};

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_CTR_A_VALUE)   || (i == IDX_CTR_A_CONTROL) ||
                (i == IDX_CTR_B_HIGH)    || (i == IDX_CTR_B_LOW)     ||
                (i == IDX_CTR_B_CONTROL) || (i == IDX_IRQ_STATUS)    ||
                (i == IDX_PORT_CTRL);
  endfunction

  // Zero wait states; unmapped words answer with an error
  assign mapped   = is_mapped(idx);
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = prdata_reg;

  // Clock held off for the whole read of a value word
  assign block_a = psel & ~pwrite & (idx == IDX_CTR_A_VALUE);
  assign block_b = psel & ~pwrite & (idx == IDX_CTR_B_HIGH);

  // Preload reaches the count only while halted
  assign load_a = wr & (idx == IDX_CTR_A_VALUE) & ~a_ctrl_reg.run;
  assign load_b = wr & (idx == IDX_CTR_B_HIGH) & ~b_ctrl_reg.run;

  // Prescaler and PWM period count
  prescale_gen u_prescale (
    .pclk         (pclk),
    .presetn      (presetn),
    .sel          (a_ctrl_reg.presc),
    .div_count    (pwm_count),
    .tick_a       (tick_a),
    .tick_quarter (tick_quarter)
  );

  // Slow source edge; taken as synchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_prev_reg <= 1'b0;
    end else begin
      slow_prev_reg <= slow_clk_in;
    end
  end

  assign slow_tick = slow_clk_in & ~slow_prev_reg;
  assign tick_b    = b_ctrl_reg.clk_sel ? slow_tick : tick_quarter;

  count_core #(.WIDTH(8)) u_ctr_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .mode         (a_ctrl_reg.mode),
    .edge_sel     (a_ctrl_reg.edge_sel),
    .run          (a_ctrl_reg.run),
    .int_tick     (tick_a),
    .event_in     (ctr_a_event_input),
    .block        (block_a),
    .load         (load_a),
    .load_val     (pwdata[7:0]),
    .preload      (a_preload_reg),
    .count        (count_a),
    .overflow     (ovf_a),
    .measure_done (done_a)
  );

  count_core #(.WIDTH(16)) u_ctr_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .mode         (b_ctrl_reg.mode),
    .edge_sel     (b_ctrl_reg.edge_sel),
    .run          (b_ctrl_reg.run),
    .int_tick     (tick_b),
    .event_in     (ctr_b_event_input),
    .block        (block_b),
    .load         (load_b),
    .load_val     ({pwdata[7:0], b_low_buf_reg}),
    .preload      (b_preload_reg),
    .count        (count_b),
    .overflow     (ovf_b),
    .measure_done (done_b)
  );

  // Control registers; end of a measurement drops run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ctrl_reg <= ctr_ctrl_t'(CTRL_RESET);
      b_ctrl_reg <= ctr_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr && idx == IDX_CTR_A_CONTROL) begin
        a_ctrl_reg <= ctr_ctrl_t'(pwdata[7:0] & CTR_A_CTRL_MASK);
      end else if (done_a) begin
        a_ctrl_reg.run <= 1'b0;
      end
      if (wr && idx == IDX_CTR_B_CONTROL) begin
        b_ctrl_reg <= ctr_ctrl_t'(pwdata[7:0] & CTR_B_CTRL_MASK);
      end else if (done_b) begin
        b_ctrl_reg.run <= 1'b0;
      end
    end
  end

  // Preloads: always written, counter untouched while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_preload_reg <= BYTE_RESET;
      b_preload_reg <= COUNT_RESET;
    end else begin
      if (wr && idx == IDX_CTR_A_VALUE) begin
        a_preload_reg <= pwdata[7:0];
      end
      if (wr && idx == IDX_CTR_B_HIGH) begin
        b_preload_reg <= {pwdata[7:0], b_low_buf_reg};
      end
    end
  end

  // Low-byte buffer: written by software, or caught on a high read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_low_buf_reg <= BYTE_RESET;
    end else if (wr && idx == IDX_CTR_B_LOW) begin
      b_low_buf_reg <= pwdata[7:0];
    end else if (rd && idx == IDX_CTR_B_HIGH) begin
      b_low_buf_reg <= count_b[7:0];
    end
  end

  // Flags and enables; an overflow wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_irq_en_reg <= 1'b0;
      b_irq_en_reg <= 1'b0;
      a_flag_reg   <= 1'b0;
      b_flag_reg   <= 1'b0;
    end else begin
      if (wr && idx == IDX_IRQ_STATUS) begin
        a_irq_en_reg <= pwdata[IRQ_A_EN_BIT];
        b_irq_en_reg <= pwdata[IRQ_B_EN_BIT];
        a_flag_reg   <= pwdata[IRQ_A_FLG_BIT] | ovf_a;
        b_flag_reg   <= pwdata[IRQ_B_FLG_BIT] | ovf_b;
      end else begin
        a_flag_reg <= a_flag_reg | ovf_a;
        b_flag_reg <= b_flag_reg | ovf_b;
      end
    end
  end

  // Request only where enabled, in every mode
  assign ctr_a_irq = a_flag_reg & a_irq_en_reg;
  assign ctr_b_irq = b_flag_reg & b_irq_en_reg;

  // Pin latch and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_latch_reg <= 1'b0;
      pin_dir_reg   <= 1'b0;
    end else if (wr && idx == IDX_PORT_CTRL) begin
      pin_latch_reg <= pwdata[PORT_LATCH_BIT];
      pin_dir_reg   <= pwdata[PORT_DIR_BIT];
    end
  end

  // Only one overflow feeds the divider, chosen by option
  assign sel_ovf = divider_from_ctr_b ? ovf_b : ovf_a;

  // Divide-by-two level and wake-up pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_reg <= 1'b0;
      wake_reg    <= 1'b0;
    end else begin
      divider_reg <= divider_reg ^ sel_ovf;
      wake_reg    <= ovf_a | ovf_b;
    end
  end

  assign wake_up = wake_reg;

  // Input direction keeps the plain input; latch gates the divider
  assign shared_divider_pin_oe  = pin_dir_reg;
  assign shared_divider_pin_out = divider_option_en ?
                                  (pin_latch_reg & divider_reg) :
                                  pin_latch_reg;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_reg <= 32'h0000_0000;
      unique case (idx)
        IDX_CTR_A_VALUE:   prdata_reg[7:0] <= count_a;
        IDX_CTR_A_CONTROL: prdata_reg[7:0] <= a_ctrl_reg;
        IDX_CTR_B_HIGH:    prdata_reg[7:0] <= count_b[15:8];
        IDX_CTR_B_LOW:     prdata_reg[7:0] <= b_low_buf_reg;
        IDX_CTR_B_CONTROL: prdata_reg[7:0] <= b_ctrl_reg & CTR_B_CTRL_MASK;
        IDX_IRQ_STATUS: begin
          prdata_reg[IRQ_A_EN_BIT]  <= a_irq_en_reg;
          prdata_reg[IRQ_B_EN_BIT]  <= b_irq_en_reg;
          prdata_reg[IRQ_A_FLG_BIT] <= a_flag_reg;
          prdata_reg[IRQ_B_FLG_BIT] <= b_flag_reg;
        end
        IDX_PORT_CTRL: begin
          prdata_reg[PORT_LATCH_BIT] <= pin_latch_reg;
          prdata_reg[PORT_DIR_BIT]   <= pin_dir_reg;
          prdata_reg[PORT_PIN_BIT]   <= shared_divider_pin_in;
        end
        default:           prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control B low bits never read back as ones
  b_ctrl_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_rd && idx == IDX_CTR_B_CONTROL) |=> (prdata[2:0] == 3'b000))
    else $error("counter B control low bits not zero");

  // Run falls the cycle after a measurement ends
  run_auto_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (done_b && !(wr && idx == IDX_CTR_B_CONTROL)) |=> !b_ctrl_reg.run)
    else $error("run not cleared after measurement");

  // Every overflow gives a wake-up pulse one cycle later
  wake_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_a || ovf_b) |=> wake_up)
    else $error("overflow without wake-up");

  // Clearing the enable drops the request on the next cycle
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == IDX_IRQ_STATUS && !pwdata[IRQ_A_EN_BIT]) |=> !ctr_a_irq)
    else $error("irq A requested while disabled");

  // Halted write reaches the count
  load_halted_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == IDX_CTR_A_VALUE && !a_ctrl_reg.run)
      |=> (count_a == $past(pwdata[7:0])))
    else $error("halted write did not load count A");

  // Running write changes the preload; load_b low the cycle after
  run_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && idx == IDX_CTR_B_HIGH && b_ctrl_reg.run && !ovf_b)
      |=> (b_preload_reg == {$past(pwdata[7:0]), $past(b_low_buf_reg)})
          && !load_b)
    else $error("running write on B misbehaved");

  // Divider flips on each chosen overflow
  divider_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel_ovf |=> (divider_reg != $past(divider_reg)))
    else $error("divider did not toggle");

  // Clear latch holds the pin low under the option
  pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (divider_option_en && !pin_latch_reg) |-> !shared_divider_pin_out)
    else $error("pin not held low");

endmodule

// ===== bench/evt_src.sv
/*
  Event source model for the counter event pins.
  Assumes one bench process calls its task at a time.
*/
`timescale 1ns/10ps
module evt_src (
  input  wire logic pclk,
  output logic      ev_a,
  output logic      ev_b
);
  // Pins rest low between pulses
  initial begin
    ev_a = 1'b0;
    ev_b = 1'b0;
  end
  // n pulses on B, w cycles high then w low
  task automatic pulse_b(input int n, input int w);
    repeat (n) begin
      @(posedge pclk) ev_b <= 1'b1;
      repeat (w) @(posedge pclk);
      ev_b <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule

// ===== bench/event_timer_with_freq_divider_tb.sv
/*
  Self-checking bench for the dual timer block over APB.
  Bench picks the divider source and drives the slow source.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected %0t got %h exp %h", $time, (a), (b)); end end
module event_timer_with_freq_divider_tb;
  import evt_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, q, lo, hi;
  logic [31:0] pwdata, prdata;
  logic        ev_a, ev_b, opt_en, pin_in, pin_out, pin_oe, pl;
  logic        irq_a, irq_b, wake, err;
  logic        slow, dsel;
  logic [2:0]  p;
  logic [6:0]  pwm, pv;
  int          bad_count, checks, cyc, seed, tog, wk, e;
  // Pin level: read back what is driven, low when floating
  assign pin_in = pin_oe ? pin_out : 1'b0;
  event_timer event_timer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctr_a_event_input(ev_a), .ctr_b_event_input(ev_b),
    .slow_clk_in(slow), .divider_option_en(opt_en),
    .divider_from_ctr_b(dsel), .shared_divider_pin_in(pin_in),
    .shared_divider_pin_out(pin_out), .shared_divider_pin_oe(pin_oe),
    .ctr_a_irq(irq_a), .ctr_b_irq(irq_b), .wake_up(wake), .pwm_count(pwm));
  evt_src evt_src_inst (.pclk(pclk), .ev_a(ev_a), .ev_b(ev_b));
  // Clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard, far above the whole run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // Verdict and end of run
  task automatic results;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; held until pready is seen high
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i[5:0], 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counter B 16-bit load and readback
  task automatic ld_b(input logic [15:0] v);
    bus(1'b1, IDX_CTR_B_LOW, v[7:0]);
    bus(1'b1, IDX_CTR_B_HIGH, v[15:8]);
  endtask
  task automatic rd_b;
    bus(1'b0, IDX_CTR_B_HIGH, 8'h00);
    hi = q;
    bus(1'b0, IDX_CTR_B_LOW, 8'h00);
    lo = q;
  endtask
  // Count pin toggles and wake pulses over n cycles
  task automatic watch(input int n);
    tog = 0;
    wk = 0;
    pl = pin_out;
    repeat (n) begin
      @(posedge pclk);
      if (pin_out !== pl) tog++;
      if (wake === 1'b1) wk++;
      pl = pin_out;
    end
  endtask
  // Main sequence
  initial begin
    seed = 96467;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    opt_en = 1'b1;
    slow = 1'b0;
    dsel = 1'b1;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h90);
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h07);
    bus(1'b0, IDX_CTR_B_CONTROL, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b0, 8'h30, 8'h00);
    `CHK(err, 1'b1)
    repeat (3) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      ld_b({hi, lo});
      bus(1'b0, IDX_CTR_B_HIGH, 8'h00);
      `CHK(q, hi)
      bus(1'b0, IDX_CTR_B_LOW, 8'h00);
      `CHK(q, lo)
    end
    $display("preload test done");
    // Event counting on both edges, then halted
    for (e = 0; e < 2; e++) begin
      ld_b(16'h0000);
      bus(1'b1, IDX_CTR_B_CONTROL, 8'h50 | 8'(e << 3));
      evt_src_inst.pulse_b(3, 2);
      repeat (4) @(posedge pclk);
      bus(1'b1, IDX_CTR_B_CONTROL, 8'h40 | 8'(e << 3));
      evt_src_inst.pulse_b(2, 2);
      rd_b();
      `CHK({hi, lo}, 16'd3)
    end
    ld_b(16'h0000);
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h10);
    repeat (20) @(posedge pclk);
    rd_b();
    `CHK({hi, lo}, 16'd0)
    $display("event test done");
    // Running write touches only the preload
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h90);
    ld_b(16'hffff);
    bus(1'b0, IDX_CTR_B_HIGH, 8'h00);
    `CHK(q, 8'h00)
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h80);
    ld_b(16'hfffe);
    bus(1'b1, IDX_IRQ_STATUS, 8'h00);
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h90);
    watch(40);
    `CHK(irq_b, 1'b0)
    `CHK(wk > 0, 1'b1)
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    `CHK(q[IRQ_B_FLG_BIT], 1'b1)
    bus(1'b1, IDX_IRQ_STATUS, 8'h02);
    repeat (40) @(posedge pclk);
    `CHK(irq_b, 1'b1)
    bus(1'b1, IDX_PORT_CTRL, 8'h02);
    watch(40);
    `CHK(tog, 0)
    `CHK(pin_oe, 1'b1)
    bus(1'b1, IDX_PORT_CTRL, 8'h03);
    watch(80);
    `CHK(tog >= 9 && tog <= 11, 1'b1)
    bus(1'b1, IDX_PORT_CTRL, 8'h01);
    @(posedge pclk);
    `CHK(pin_oe, 1'b0)
    $display("timer test done");
    // Single pulse-width measurement
    bus(1'b1, IDX_CTR_B_CONTROL, 8'h80);
    ld_b(16'h0000);
    bus(1'b1, IDX_CTR_B_CONTROL, 8'hd8);
    evt_src_inst.pulse_b(1, 20);
    repeat (4) @(posedge pclk);
    bus(1'b0, IDX_CTR_B_CONTROL, 8'h00);
    `CHK(q[4], 1'b0)
    rd_b();
    `CHK(hi == 0 && lo >= 4 && lo <= 6, 1'b1)
    q = lo;
    evt_src_inst.pulse_b(1, 20);
    rd_b();
    `CHK(lo, q)
    $display("pulse test done");
    // Slow source clocks counter B when selected
    ld_b(16'h0000);
    bus(1'b1, IDX_CTR_B_CONTROL, 8'hb0);
    repeat (6) begin
      @(posedge pclk) slow <= 1'b1;
      repeat (3) @(posedge pclk);
      slow <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    bus(1'b1, IDX_CTR_B_CONTROL, 8'ha0);
    rd_b();
    `CHK({hi, lo}, 16'd6)
    // Counter A timer at a random prescale: 203 run cycles >> code
    p = 3'($random(seed));
    bus(1'b1, IDX_CTR_A_VALUE, 8'h00);
    bus(1'b1, IDX_CTR_A_CONTROL, 8'h90 | 8'(p));
    repeat (200) @(posedge pclk);
    bus(1'b1, IDX_CTR_A_CONTROL, 8'h80 | 8'(p));
    bus(1'b0, IDX_CTR_A_VALUE, 8'h00);
    e = 203 >> p;
    `CHK(q >= 8'(e) && q <= 8'(e + 1), 1'b1)
    // Divider fed by counter A, overflow every two cycles
    dsel <= 1'b0;
    bus(1'b1, IDX_CTR_A_VALUE, 8'hfe);
    bus(1'b1, IDX_IRQ_STATUS, 8'h01);
    bus(1'b1, IDX_CTR_A_CONTROL, 8'h90);
    watch(40);
    `CHK(tog >= 19 && tog <= 21, 1'b1)
    `CHK(irq_a, 1'b1)
    // Prescaler count advances once per cycle
    pv = pwm;
    repeat (37) @(posedge pclk);
    `CHK(7'(pwm - pv), 7'd37)
    $display("counter A test done");
    results();
  end
endmodule
